/* File: core/dduc_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dduc_consts.svh"

module dduc_channel (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              ctlWr,
   input  wire logic              lowWr,
   input  wire logic              highWr,
   input  wire dduc_pkg::dduc_byte_t wrData,
   input  wire logic              timer2Ovf,
   input  wire logic              timer3Ovf,
   input  wire logic              timer4Ovf,
   output var  dduc_pkg::dduc_byte_t ctlValue,
   output var  dduc_pkg::dduc_byte_t lowValue,
   output var  dduc_pkg::dduc_byte_t highValue,
   output var  dduc_pkg::dduc_word_t convWord,
   output var  logic              convEnable
);
   import dduc_pkg::*;

   dduc_byte_t ctl_reg,     ctl_next;
   dduc_byte_t pendLow_reg, pendLow_next;
   dduc_byte_t pendHi_reg,  pendHi_next;
   dduc_byte_t latLow_reg,  latLow_next;
   dduc_byte_t latHi_reg,   latHi_next;
   dduc_word_t word_reg,    word_next;
   logic       en_reg,      en_next;
   dduc_mode_t mode;
   logic       update;

   // place the latched bytes into a 12-bit word per format code
   function automatic dduc_word_t justify(input dduc_byte_t hi,
                                          input dduc_byte_t lo,
                                          input logic [2:0] fmt);
      dduc_word_t w;
      w = `DDUC_WORD_RESET;
      if (fmt[2]) begin
         w = {hi[7:0], lo[7:4]};
      end else begin
         unique case (fmt[1:0])
            2'b00: w = {hi[3:0], lo[7:0]};
            2'b01: w = {hi[4:0], lo[7:1]};
            2'b10: w = {hi[5:0], lo[7:2]};
            2'b11: w = {hi[6:0], lo[7:3]};
         endcase
      end
      return w;
   endfunction

   assign mode = dduc_mode_t'(ctl_reg[`DDUC_CTL_MODE_MSB:`DDUC_CTL_MODE_LSB]);

   // pick the update event; strobes are same-clock, no synchroniser
   always_comb begin
      update = 1'b0;
      unique case (mode)
         DDUC_UPD_ON_WRITE: update = highWr;
         DDUC_UPD_TIMER3:   update = timer3Ovf;
         DDUC_UPD_TIMER4:   update = timer4Ovf;
         DDUC_UPD_TIMER2:   update = timer2Ovf;
      endcase
   end

   // holding bytes, latches and the formatted converter word
   always_comb begin
      ctl_next     = ctl_reg;
      pendLow_next = pendLow_reg;
      pendHi_next  = pendHi_reg;
      latLow_next  = latLow_reg;
      latHi_next   = latHi_reg;
      if (ctlWr) begin
         ctl_next = wrData & `DDUC_CTL_WMASK;
      end
      if (lowWr) begin
         pendLow_next = wrData;
      end
      if (highWr) begin
         pendHi_next = wrData;
      end
      // a write in the same cycle as the update is included
      if (update) begin
         latLow_next = pendLow_next;
         latHi_next  = pendHi_next;
      end
      word_next = justify(latHi_reg, latLow_reg,
                          ctl_reg[`DDUC_CTL_FMT_MSB:`DDUC_CTL_FMT_LSB]);
      en_next   = ctl_reg[`DDUC_CTL_EN_BIT];
   end

   // everything clears on reset: disabled, on-write mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_reg     <= `DDUC_BYTE_RESET;
         pendLow_reg <= `DDUC_BYTE_RESET;
         pendHi_reg  <= `DDUC_BYTE_RESET;
         latLow_reg  <= `DDUC_BYTE_RESET;
         latHi_reg   <= `DDUC_BYTE_RESET;
         word_reg    <= `DDUC_WORD_RESET;
         en_reg      <= 1'b0;
      end else if (ce) begin
         ctl_reg     <= ctl_next;
         pendLow_reg <= pendLow_next;
         pendHi_reg  <= pendHi_next;
         latLow_reg  <= latLow_next;
         latHi_reg   <= latHi_next;
         word_reg    <= word_next;
         en_reg      <= en_next;
      end
   end

   // low reads the written value, high reads the latch
   assign ctlValue   = ctl_reg;
   assign lowValue   = pendLow_reg;
   assign highValue  = latHi_reg;
   assign convWord   = word_reg;
   assign convEnable = en_reg;

endmodule // dduc_channel

`default_nettype wire

/* File: core/dduc_consts.svh */
`ifndef DDUC_CONSTS_SVH
`define DDUC_CONSTS_SVH

// register byte addresses in the special-function space
`define DDUC_ADDR_CONV0_LOW   8'hD2
`define DDUC_ADDR_CONV0_HIGH  8'hD3
`define DDUC_ADDR_CONV0_CTL   8'hD4
`define DDUC_ADDR_CONV1_LOW   8'hD5
`define DDUC_ADDR_CONV1_HIGH  8'hD6
`define DDUC_ADDR_CONV1_CTL   8'hD7

// control field positions
`define DDUC_CTL_EN_BIT       7
`define DDUC_CTL_MODE_MSB     4
`define DDUC_CTL_MODE_LSB     3
`define DDUC_CTL_FMT_MSB      2
`define DDUC_CTL_FMT_LSB      0

// writable control bits, bits 6 and 5 masked off
`define DDUC_CTL_WMASK        8'h9F

// reset values
`define DDUC_BYTE_RESET       8'h00
`define DDUC_WORD_RESET       12'h000

`endif

/* File: core/dduc_pkg.sv */
`default_nettype none
package dduc_pkg;

   // update source selected by the control mode field
   typedef enum logic [1:0] {
      DDUC_UPD_ON_WRITE = 2'b00,
      DDUC_UPD_TIMER3   = 2'b01,
      DDUC_UPD_TIMER4   = 2'b10,
      DDUC_UPD_TIMER2   = 2'b11
   } dduc_mode_t;

   typedef logic [7:0]  dduc_byte_t;
   typedef logic [11:0] dduc_word_t;

endpackage : dduc_pkg

`default_nettype wire

/* File: core/dduc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dduc_consts.svh"

// Notes on behaviour
// - enable bit 7 powers channel output
// - control bits 6:5 read zero, ignored
// - mode 00 latches on high byte write
// - mode 01 latches on timer 3 overflow
// - mode 10 latches on timer 4 overflow
// - mode 11 latches on timer 2 overflow
// - format 000: high[3:0], low[7:0]
// - format 001: high[4:0], low[7:1]
// - format 010: high[5:0], low[7:2]
// - format 011: high[6:0], low[7:3]
// - format 1xx: high[7:0], low[7:4]
// - second channel, identical and independent
// - low writes wait for high write in mode 00
// - timer modes hold both bytes until overflow
// - low reads written value, high reads latch
module dduc_top (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   input  wire logic [7:0]           sfrAddr,
   input  wire dduc_pkg::dduc_byte_t sfrWrData,
   input  wire logic                 sfrWrEn,
   input  wire logic                 sfrRdEn,
   output var  dduc_pkg::dduc_byte_t sfrRdData,
   input  wire logic                 timer2Ovf,
   input  wire logic                 timer3Ovf,
   input  wire logic                 timer4Ovf,
   output var  dduc_pkg::dduc_word_t conv0Word,
   output var  dduc_pkg::dduc_word_t conv1Word,
   output var  logic                 conv0Enable,
   output var  logic                 conv1Enable
);
   import dduc_pkg::*;

   localparam int NCH = 2;

   // per-channel addresses, index 0 and 1
   localparam logic [7:0] ADDR_LOW  [NCH] =
      '{`DDUC_ADDR_CONV0_LOW,  `DDUC_ADDR_CONV1_LOW};
   localparam logic [7:0] ADDR_HIGH [NCH] =
      '{`DDUC_ADDR_CONV0_HIGH, `DDUC_ADDR_CONV1_HIGH};
   localparam logic [7:0] ADDR_CTL  [NCH] =
      '{`DDUC_ADDR_CONV0_CTL,  `DDUC_ADDR_CONV1_CTL};

   dduc_byte_t chCtl  [NCH];
   dduc_byte_t chLow  [NCH];
   dduc_byte_t chHigh [NCH];
   dduc_word_t chWord [NCH];
   logic       chEn   [NCH];
   dduc_byte_t rdData_reg, rdData_next;

   // one channel instance per converter, same behaviour each
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      dduc_channel u_ch (
         .clk        (clk),
         .nrst       (nrst),
         .ce         (ce),
         .ctlWr      (sfrWrEn && (sfrAddr == ADDR_CTL[i])),
         .lowWr      (sfrWrEn && (sfrAddr == ADDR_LOW[i])),
         .highWr     (sfrWrEn && (sfrAddr == ADDR_HIGH[i])),
         .wrData     (sfrWrData),
         .timer2Ovf  (timer2Ovf),
         .timer3Ovf  (timer3Ovf),
         .timer4Ovf  (timer4Ovf),
         .ctlValue   (chCtl[i]),
         .lowValue   (chLow[i]),
         .highValue  (chHigh[i]),
         .convWord   (chWord[i]),
         .convEnable (chEn[i])
      );
   end

   // read data registered; unmapped addresses read zero and hold
   // the last answer when no read is pending
   always_comb begin
      rdData_next = rdData_reg;
      if (sfrRdEn) begin
         rdData_next = `DDUC_BYTE_RESET;
         for (int i = 0; i < NCH; i++) begin
            if (sfrAddr == ADDR_CTL[i]) begin
               rdData_next = chCtl[i];
            end
            if (sfrAddr == ADDR_LOW[i]) begin
               rdData_next = chLow[i];
            end
            if (sfrAddr == ADDR_HIGH[i]) begin
               rdData_next = chHigh[i];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_reg <= `DDUC_BYTE_RESET;
      end else if (ce) begin
         rdData_reg <= rdData_next;
      end
   end

   // all outputs are channel or read flip-flops
   assign sfrRdData   = rdData_reg;
   assign conv0Word   = chWord[0];
   assign conv1Word   = chWord[1];
   assign conv0Enable = chEn[0];
   assign conv1Enable = chEn[1];

endmodule // dduc_top

`default_nettype wire

/* File: verification/dduc_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dduc_timer_model (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [2:0] fire,
   output var  logic       t2Ovf,
   output var  logic       t3Ovf,
   output var  logic       t4Ovf
);
   logic [2:0] strobeReg;
   // one-cycle strobes on the system clock, so no resync stage is needed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         strobeReg <= 3'h0;
      else
         strobeReg <= fire;
   end
   assign t2Ovf = strobeReg[0];
   assign t3Ovf = strobeReg[1];
   assign t4Ovf = strobeReg[2];
endmodule // dduc_timer_model
`default_nettype wire

/* File: verification/dduc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dduc_top_asserts (
   input wire logic                 clk,
   input wire logic                 nrst,
   input wire logic                 ce,
   input wire logic [7:0]           sfrAddr,
   input wire dduc_pkg::dduc_byte_t sfrWrData,
   input wire logic                 sfrWrEn,
   input wire logic                 sfrRdEn,
   input wire dduc_pkg::dduc_byte_t sfrRdData,
   input wire logic                 timer2Ovf,
   input wire logic                 timer3Ovf,
   input wire logic                 timer4Ovf,
   input wire dduc_pkg::dduc_word_t conv0Word,
   input wire dduc_pkg::dduc_word_t conv1Word,
   input wire logic                 conv0Enable,
   input wire logic                 conv1Enable
);
   import dduc_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // enable follows the control write two running edges on
   property p_en0;
      ce && sfrWrEn && sfrAddr == 8'hD4 ##1 ce |=>
         conv0Enable == $past(sfrWrData[7], 2);
   endproperty
   a_en0: assert property (p_en0) else $error("en0");
   property p_en1;
      ce && sfrWrEn && sfrAddr == 8'hD7 ##1 ce |=>
         conv1Enable == $past(sfrWrData[7], 2);
   endproperty
   a_en1: assert property (p_en1) else $error("en1");
   // a control read right after its write sees bits 6:5 cleared
   property p_ctlRd;
      ce && sfrWrEn && sfrAddr == 8'hD4 ##1
         ce && sfrRdEn && sfrAddr == 8'hD4 |=>
         sfrRdData == ($past(sfrWrData, 2) & 8'h9F);
   endproperty
   a_ctlRd: assert property (p_ctlRd) else $error("ctl rd");
   property p_lowRd;
      ce && sfrWrEn && sfrAddr == 8'hD2 ##1
         ce && sfrRdEn && sfrAddr == 8'hD2 |=>
         sfrRdData == $past(sfrWrData, 2);
   endproperty
   a_lowRd: assert property (p_lowRd) else $error("low rd");
   // unmapped reads answer zero
   property p_unmap;
      ce && sfrRdEn && (sfrAddr < 8'hD2 || sfrAddr > 8'hD7) |=>
         sfrRdData == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped rd");
   property p_stand;
      !sfrRdEn |=> $stable(sfrRdData);
   endproperty
   a_stand: assert property (p_stand) else $error("rd data moved");
   // two cycles with no write and no strobe mean the converters must not move
   property p_hold;
      (!sfrWrEn && !timer2Ovf && !timer3Ovf && !timer4Ovf)[*2] |=>
         $stable(conv0Word) && $stable(conv1Word) &&
         $stable(conv0Enable) && $stable(conv1Enable);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_rst;
      $rose(nrst) |-> conv0Word == 12'h000 && conv1Word == 12'h000 &&
         !conv0Enable && !conv1Enable;
   endproperty
   a_rst: assert property (p_rst) else $error("reset");
endmodule // dduc_top_asserts
bind dduc_top dduc_top_asserts chk_u (.clk, .nrst, .ce, .sfrAddr,
   .sfrWrData, .sfrWrEn, .sfrRdEn, .sfrRdData, .timer2Ovf, .timer3Ovf,
   .timer4Ovf, .conv0Word, .conv1Word, .conv0Enable, .conv1Enable);
`default_nettype wire

/* File: verification/dual_dac_update_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_dac_update_control_tb;
   import dduc_pkg::*;
   logic       clk, nrst, ce, wrEn, rdEn, t2, t3, t4, en0, en1;
   logic [7:0] addr;
   logic [2:0] fire;
   dduc_byte_t wrData, rdData, oh, ol;
   dduc_word_t w0, w1;
   int         num_errors = 0;
   int         n_tests = 0;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ce is driven so that one scenario can stall the whole block
   dduc_top dut_u (.clk, .nrst, .ce(ce), .sfrAddr(addr),
      .sfrWrData(wrData), .sfrWrEn(wrEn), .sfrRdEn(rdEn), .sfrRdData(rdData),
      .timer2Ovf(t2), .timer3Ovf(t3), .timer4Ovf(t4), .conv0Word(w0),
      .conv1Word(w1), .conv0Enable(en0), .conv1Enable(en1));
   dduc_timer_model tmr_u (.clk, .nrst, .fire, .t2Ovf(t2), .t3Ovf(t3),
      .t4Ovf(t4));
   task chk(input string what, input logic [11:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test;
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one bus cycle per edge, so tasks chain back to back
   task access(input logic w, r, input logic [7:0] a, d);
      @(posedge clk);
      wrEn <= w;
      rdEn <= r;
      addr <= a;
      wrData <= d;
   endtask
   task cyc(input int n);
      repeat (n) access(1'b0, 1'b0, 8'h00, 8'h00);
      #1;
   endtask
   task wr(input logic [7:0] a, d);
      access(1'b1, 1'b0, a, d);
   endtask
   task rd(input logic [7:0] a, exp, input string what);
      access(1'b0, 1'b1, a, 8'h00);
      cyc(1);
      chk(what, {4'h0, rdData}, {4'h0, exp});
   endtask
   task pulse(input int i);
      @(posedge clk);
      fire <= 3'h1 << i;
      @(posedge clk);
      fire <= 3'h0;
      cyc(2);
   endtask
   function dduc_word_t just(input logic [2:0] f, input dduc_byte_t h, l);
      case (f)
         3'h0: return {h[3:0], l};
         3'h1: return {h[4:0], l[7:1]};
         3'h2: return {h[5:0], l[7:2]};
         3'h3: return {h[6:0], l[7:3]};
         default: return {h, l[7:4]};
      endcase
   endfunction
   task t_reset;
      for (int a = 8'hD2; a <= 8'hD7; a++) rd(8'(a), 8'h00, "rst reg");
      chk("rst words", {w0 | w1}, 12'h000);
   endtask
   task t_ctl;
      wr(8'hD4, 8'hFF);
      rd(8'hD4, 8'h9F, "ctl bits");
      chk("en0 on", {11'h0, en0}, 12'h001);
      chk("en1 off", {11'h0, en1}, 12'h000);
      wr(8'hD4, 8'h60);
      rd(8'hD4, 8'h00, "ctl unused");
      chk("en0 off", {11'h0, en0}, 12'h000);
      rd(8'hD1, 8'h00, "unmapped");
   endtask
   task t_format;
      oh = 8'h00;
      ol = 8'h00;
      for (int f = 0; f < 8; f++) begin
         wr(8'hD4, {5'h10, 3'(f)});
         wr(8'hD2, {~3'(f), 5'h15});
         rd(8'hD2, {~3'(f), 5'h15}, "low rd");
         cyc(2);
         chk("low held", w0, just(3'(f), oh, ol));
         wr(8'hD3, {3'(f), 5'h0A});
         cyc(2);
         oh = {3'(f), 5'h0A};
         ol = {~3'(f), 5'h15};
         chk("word0", w0, just(3'(f), oh, ol));
      end
      chk("ch1 apart", w1, 12'h000);
   endtask
   task t_timer;
      int ti;
      oh = 8'h00;
      ol = 8'h00;
      for (int m = 1; m < 4; m++) begin
         ti = (m == 3) ? 0 : m;
         wr(8'hD7, {3'h4, 2'(m), 3'h4});
         wr(8'hD5, 8'(8'h30 * m));
         wr(8'hD6, 8'(8'h21 * m));
         cyc(2);
         rd(8'hD6, oh, "high latch");
         chk("en1 on", {11'h0, en1}, 12'h001);
         pulse((ti + 1) % 3);
         pulse((ti + 2) % 3);
         chk("held", w1, {oh, ol[7:4]});
         pulse(ti);
         oh = 8'(8'h21 * m);
         ol = 8'(8'h30 * m);
         chk("timer upd", w1, {oh, ol[7:4]});
      end
   endtask
   // ce low must stall writes, reads and both outputs
   task t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      wr(8'hD7, 8'h00);
      wr(8'hD6, 8'h00);
      access(1'b0, 1'b1, 8'hD6, 8'h00);
      cyc(2);
      chk("frozen en1", {11'h0, en1}, 12'h001);
      chk("frozen word1", w1, {oh, ol[7:4]});
      chk("frozen rd", {4'h0, rdData}, 12'h042);
      @(posedge clk);
      ce <= 1'b1;
      rd(8'hD7, 8'h9C, "ctl kept");
   endtask
   initial begin
      {nrst, wrEn, rdEn, addr, wrData, fire} = '0;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_ctl();
      t_format();
      t_timer();
      t_freeze();
      end_of_test();
   end
   // a hang counts as a mismatch
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
endmodule // dual_dac_update_control_tb
`default_nettype wire
